// ===== verilog/mem_space_consts.vh
// Memory map, configuration field and timing constants for the decoder
`ifndef MEM_SPACE_CONSTS_VH
`define MEM_SPACE_CONSTS_VH
`define GP_RAM_LAST 8'hff
`define UPPER_BASE 8'h80
`define BIT_RAM_BASE 8'h20
`define MEMORY_CONFIG_ADDR 8'haf
`define MEMORY_CONFIG_RESET 8'h00
`define EXTENDED_RAM_ENABLE_LSB 0
`define EXTENDED_RAM_ENABLE_MSB 1
`define EXTENDED_RAM_ENABLE_ON 2'h1
`define EXTENDED_RAM_LAST 16'h00ff
`define CODE_LAST 16'h3fff
// Addressing modes
`define MODE_IMMEDIATE 3'h0
`define MODE_PTR_LOAD 3'h1
`define MODE_DIRECT 3'h2
`define MODE_REGISTER 3'h3
`define MODE_INDIRECT 3'h4
`define MODE_EXT_DIRECT 3'h5
`define MODE_EXT_INDIRECT 3'h6
`define MODE_CODE_DATA_POINTER 3'h7
`define MODE_CODE_PC 4'h8
`define MODE_INDEX_JUMP 4'h9
`define MODE_BIT 4'ha
// Target spaces
`define SPACE_NONE 3'h0
`define SPACE_RAM 3'h1
`define SPACE_SFR 3'h2
`define SPACE_EXTENDED_RAM 3'h3
`define SPACE_CODE 3'h4
// Instruction bytes and core cycles
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
`define CYC_1 4'h1
`define CYC_2 4'h2
`define CYC_3 4'h3
`define CYC_4 4'h4
`endif

// ===== verilog/memory_space_addressing_decoder.v
// Address space and addressing mode decoder for the 8-bit core
//
// Operation
// - General RAM holds 256 bytes, 0x00 to 0xFF, register banks inside.
// - Addresses 0x00-0x7F reach the same RAM directly or indirectly.
// - Direct 0x80-0xFF goes to special function registers only.
// - Indirect 0x80-0xFF reaches upper RAM, never a special register.
// - Bit addresses 0x00-0x7F map to bits of RAM bytes 0x20-0x2F.
// - Bits of bit-addressable special registers can be set, cleared, tested.
// - Extended RAM 256 bytes at 0x0000-0x00FF, extended moves only.
// - Writing 01 to bits 1:0 of register 0xAF enables extended RAM.
// - Extended moves allowed when either enable bit is one.
// - Code and constants live in 16 kbyte flash, read code-indexed.
// - Extended direct uses data pointer; 1 byte, 4 cycles.
// - Extended indirect uses index register; 1 byte, 4 cycles.
// - Code reads fetch A plus data pointer or program counter; 4 cycles.
// - Mode timing: immediate, pointer load, direct, register, indirect, jump.
// - Most instructions take one or two cycles, 4 instruction_rate peak.
// - Add register is 1 byte 1 cycle; add indirect 1 byte 2 cycles.
`timescale 1ns/1ps
`include "mem_space_consts.vh"
module memory_space_addressing_decoder #(
  parameter ADDR_W = 16
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_req,
  input wire [3:0] i_mode,
  input wire [7:0] i_addr,
  input wire [7:0] i_index_register,
  input wire [15:0] i_data_pointer,
  input wire [15:0] i_program_counter,
  input wire [7:0] i_accumulator,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  output reg o_valid,
  output reg [2:0] o_space,
  output reg [ADDR_W-1:0] o_addr,
  output reg [2:0] o_bit_pos,
  output reg o_bit_access,
  output reg [1:0] o_len,
  output reg [3:0] o_cycles,
  output reg o_fault,
  output reg [7:0] o_memory_config
);

  // Address into the flash for a code-indexed read, wrapped to 16 kbyte
  function [15:0] code_addr;
    input [15:0] base;
    input [7:0] acc;
    begin
      code_addr = (base + {8'h00, acc}) & `CODE_LAST;
    end
  endfunction

  reg [2:0] next_space;
  reg [15:0] next_addr;
  reg [2:0] next_bit_pos;
  reg next_bit_access;
  reg [1:0] next_len;
  reg [3:0] next_cycles;
  reg next_fault;
  wire extended_ram_enable_field;

  // Either enable bit grants extended moves
  assign extended_ram_enable_field = |o_memory_config[`EXTENDED_RAM_ENABLE_MSB:
                                              `EXTENDED_RAM_ENABLE_LSB];

  // Configuration register at its special function address
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_memory_config <= `MEMORY_CONFIG_RESET;
    end else if (i_sfr_wr && i_addr == `MEMORY_CONFIG_ADDR) begin
      o_memory_config <= i_sfr_wdata;
    end
  end

  // Decode the target space, address, length and cycle count
  always @* begin
    next_space = `SPACE_NONE;
    next_addr = 16'h0000;
    next_bit_pos = 3'h0;
    next_bit_access = 1'b0;
    next_len = `LEN_1;
    next_cycles = `CYC_1;
    next_fault = 1'b0;
    case (i_mode)
      {1'b0, `MODE_IMMEDIATE}: begin
        next_len = `LEN_2;
        next_cycles = `CYC_2;
      end
      {1'b0, `MODE_PTR_LOAD}: begin
        next_len = `LEN_3;
        next_cycles = `CYC_3;
      end
      {1'b0, `MODE_DIRECT}: begin
        next_addr = {8'h00, i_addr};
        next_len = `LEN_2;
        next_cycles = `CYC_2;
        if (i_addr >= `UPPER_BASE) begin
          next_space = `SPACE_SFR;
        end else begin
          next_space = `SPACE_RAM;
        end
      end
      {1'b0, `MODE_REGISTER}: begin
        // Bank register lives in the low RAM bytes
        next_space = `SPACE_RAM;
        next_addr = {11'h000, i_addr[4:0]};
        next_len = `LEN_1;
        next_cycles = `CYC_1;
      end
      {1'b0, `MODE_INDIRECT}: begin
        next_space = `SPACE_RAM;
        next_addr = {8'h00, i_index_register};
        next_len = `LEN_1;
        next_cycles = `CYC_2;
      end
      {1'b0, `MODE_EXT_DIRECT}: begin
        next_len = `LEN_1;
        next_cycles = `CYC_4;
        next_addr = i_data_pointer;
        if (extended_ram_enable_field && i_data_pointer <= `EXTENDED_RAM_LAST) begin
          next_space = `SPACE_EXTENDED_RAM;
        end else begin
          next_fault = 1'b1; // No external data memory
        end
      end
      {1'b0, `MODE_EXT_INDIRECT}: begin
        next_len = `LEN_1;
        next_cycles = `CYC_4;
        next_addr = {8'h00, i_index_register};
        if (extended_ram_enable_field) begin
          next_space = `SPACE_EXTENDED_RAM;
        end else begin
          next_fault = 1'b1;
        end
      end
      {1'b0, `MODE_CODE_DATA_POINTER}: begin
        next_space = `SPACE_CODE;
        next_addr = code_addr(i_data_pointer, i_accumulator);
        next_cycles = `CYC_4;
      end
      `MODE_CODE_PC: begin
        next_space = `SPACE_CODE;
        next_addr = code_addr(i_program_counter, i_accumulator);
        next_cycles = `CYC_4;
      end
      `MODE_INDEX_JUMP: begin
        next_space = `SPACE_CODE;
        next_addr = code_addr(i_data_pointer, i_accumulator);
        next_cycles = `CYC_3;
      end
      `MODE_BIT: begin
        next_bit_access = 1'b1;
        next_len = `LEN_2;
        next_cycles = `CYC_2;
        next_bit_pos = i_addr[2:0];
        if (i_addr < `UPPER_BASE) begin
          next_space = `SPACE_RAM;
          next_addr = {8'h00, `BIT_RAM_BASE + {4'h0, i_addr[6:3]}};
        end else begin
          next_space = `SPACE_SFR;
          next_addr = {8'h00, i_addr[7:3], 3'h0};
        end
      end
      default: begin
        next_fault = 1'b1;
      end
    endcase
  end

  // Register the decode result
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_space <= `SPACE_NONE;
      o_addr <= {ADDR_W{1'b0}};
      o_bit_pos <= 3'h0;
      o_bit_access <= 1'b0;
      o_len <= 2'h0;
      o_cycles <= 4'h0;
      o_fault <= 1'b0;
    end else begin
      o_valid <= i_req;
      if (i_req) begin
        o_space <= next_space;
        o_addr <= next_addr[ADDR_W-1:0];
        o_bit_pos <= next_bit_pos;
        o_bit_access <= next_bit_access;
        o_len <= next_len;
        o_cycles <= next_cycles;
        o_fault <= next_fault;
      end
    end
  end

endmodule // memory_space_addressing_decoder

// ===== verif/mem_decoder_assertions.sv
// Port checks for the memory space decoder
`timescale 1ns/1ps
module mem_decoder_assertions (
  input wire i_clk, input wire i_nrst, input wire i_req,
  input wire [3:0] i_mode, input wire [7:0] i_addr,
  input wire [7:0] i_index_register, input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata, input wire o_fault,
  input wire [2:0] o_space, input wire [15:0] o_addr,
  input wire [1:0] o_len, input wire [3:0] o_cycles,
  input wire [7:0] o_memory_config
);
  // One clock, synchronous reset
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Direct and extended request qualifiers
  wire d = i_req && i_mode == 4'h2;
  wire x = i_req && (i_mode == 4'h5 || i_mode == 4'h6);
  a_direct_ram: assert property (d && !i_addr[7] |=> o_space == 3'h1)
    else $error("direct low");
  a_direct_special: assert property (d && i_addr[7] |=>
    o_space == 3'h2 && o_addr == $past(i_addr)) else $error("direct high");
  a_indirect_ram: assert property (i_req && i_mode == 4'h4 |=>
    o_space == 3'h1 && o_addr == $past(i_index_register))
    else $error("indirect");
  a_config_load: assert property (i_sfr_wr && i_addr == 8'haf |=>
    o_memory_config == $past(i_sfr_wdata)) else $error("config");
  a_ext_off: assert property (x && o_memory_config[1:0] == 2'h0 &&
    !i_sfr_wr |=> o_fault && o_space == 3'h0) else $error("ext off");
  a_ext_timing: assert property (x |=> o_len == 2'h1 &&
    o_cycles == 4'h4) else $error("ext timing");
  a_code_space: assert property (i_req &&
    (i_mode == 4'h7 || i_mode == 4'h8) |=> o_space == 3'h4 &&
    o_cycles == 4'h4) else $error("code read");
  a_reg_timing: assert property (i_req && i_mode == 4'h3 |=>
    o_len == 2'h1 && o_cycles == 4'h1) else $error("register timing");
endmodule // mem_decoder_assertions
bind memory_space_addressing_decoder mem_decoder_assertions chk_inst (
  .i_clk, .i_nrst, .i_req, .i_mode, .i_addr, .i_index_register, .i_sfr_wr,
  .i_sfr_wdata, .o_fault, .o_space, .o_addr, .o_len, .o_cycles,
  .o_memory_config);

// ===== verif/memory_space_addressing_decoder_tb.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
module memory_space_addressing_decoder_tb;
  reg i_clk = 0, i_nrst = 0, i_req = 0, i_sfr_wr = 0;
  reg [3:0] i_mode = 0;
  reg [7:0] i_addr = 0, i_index_register = 0, i_accumulator = 0;
  reg [7:0] i_sfr_wdata = 0;
  reg [15:0] i_data_pointer = 0, i_program_counter = 0;
  wire o_valid, o_bit_access, o_fault;
  wire [2:0] o_space, o_bit_pos;
  wire [15:0] o_addr;
  wire [1:0] o_len;
  wire [3:0] o_cycles;
  wire [7:0] o_memory_config;
  integer n_mismatch = 0, comparisons = 0;
  memory_space_addressing_decoder memory_space_addressing_decoder_inst (
    .i_clk, .i_nrst, .i_req, .i_mode, .i_addr, .i_index_register,
    .i_data_pointer, .i_program_counter, .i_accumulator, .i_sfr_wr,
    .i_sfr_wdata, .o_valid, .o_space, .o_addr, .o_bit_pos, .o_bit_access,
    .o_len, .o_cycles, .o_fault, .o_memory_config);
  // 200 MHz clock
  initial forever #2.5 i_clk = ~i_clk;
  task final_report;
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [15:0] g, input [15:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One request; e holds fault/space, length/cycles, address
  task run(input [3:0] m, input [7:0] a, x, input [15:0] p, input [25:0] e);
    @(negedge i_clk);
    i_req = 1;
    i_mode = m;
    i_addr = a;
    i_index_register = x;
    i_data_pointer = p;
    i_program_counter = p;
    @(negedge i_clk);
    i_req = 0;
    chk(o_valid, 1);
    chk({o_len, o_cycles}, e[21:16]);
    if (e[25:22] != 4'hf) chk({o_fault, o_space}, e[25:22]);
    if (e[25:22] < 4'h8) chk(o_addr, e[15:0]);
  endtask
  task wr(input [7:0] v);
    @(negedge i_clk);
    i_sfr_wr = 1;
    i_addr = 8'haf;
    i_sfr_wdata = v;
    @(negedge i_clk);
    i_sfr_wr = 0;
    chk(o_memory_config, v);
  endtask
  task t_map;
    run(4'h2, 8'h7f, 8'h00, 16'h0, {4'h1, 6'h22, 16'h007f});
    run(4'h4, 8'h90, 8'h7f, 16'h0, {4'h1, 6'h12, 16'h007f});
    run(4'h2, 8'h80, 8'h00, 16'h0, {4'h2, 6'h22, 16'h0080});
    run(4'h4, 8'h90, 8'hff, 16'h0, {4'h1, 6'h12, 16'h00ff});
  endtask
  task t_bits;
    run(4'ha, 8'h00, 8'h00, 16'h0, {4'h1, 6'h22, 16'h0020});
    chk({o_bit_access, o_bit_pos}, 4'h8);
    run(4'ha, 8'h7f, 8'h00, 16'h0, {4'h1, 6'h22, 16'h002f});
    chk({o_bit_access, o_bit_pos}, 4'hf);
    run(4'ha, 8'h83, 8'h00, 16'h0, {4'h2, 6'h22, 16'h0080});
    chk({o_bit_access, o_bit_pos}, 4'hb);
  endtask
  task t_ext;
    run(4'h6, 8'h00, 8'h10, 16'h0, {4'h8, 6'h14, 16'h0});
    wr(8'h01);
    run(4'h5, 8'h00, 8'h00, 16'h00ff, {4'h3, 6'h14, 16'h00ff});
    run(4'h5, 8'h00, 8'h00, 16'h0100, {4'h8, 6'h14, 16'h0});
    wr(8'h02);
    run(4'h6, 8'h00, 8'h80, 16'h0, {4'h3, 6'h14, 16'h0080});
  endtask
  task t_code;
    i_accumulator = 8'h03;
    run(4'h7, 8'h00, 8'h00, 16'h3ffe, {4'h4, 6'h14, 16'h0001});
    i_accumulator = 8'h10;
    run(4'h8, 8'h00, 8'h00, 16'h0100, {4'h4, 6'h14, 16'h0110});
  endtask
  task t_timing;
    run(4'h0, 8'h00, 8'h00, 16'h0, {4'hf, 6'h22, 16'h0});
    run(4'h1, 8'h00, 8'h00, 16'h0, {4'hf, 6'h33, 16'h0});
    run(4'h3, 8'h05, 8'h00, 16'h0, {4'hf, 6'h11, 16'h0});
    run(4'h9, 8'h00, 8'h00, 16'h0, {4'hf, 6'h13, 16'h0});
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (16) @(negedge i_clk);
    i_nrst = 1;
    chk(o_memory_config, 0);
    t_map;
    t_bits;
    t_ext;
    t_code;
    t_timing;
    final_report;
  end
  // Watchdog against a hang
  initial begin
    #5000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // memory_space_addressing_decoder_tb
